// [bench/slc_link_monitor.sv]
`timescale 1ns/1ps
`default_nettype none

module slc_link_monitor (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Link wires
   input wire logic dev_o,
   input wire logic dev_oe_n,
   input wire logic host_o,
   input wire logic host_oe_n,
   input wire logic line
);
   logic [14:0] dl_q;
   logic [14:0] hl_q;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Low run length of each end
   always_ff @(posedge aclk) begin
      dl_q <= (!aresetn || dev_oe_n) ? 15'h0000 : dl_q + 15'h0001;
      hl_q <= (!aresetn || host_oe_n) ? 15'h0000 : hl_q + 15'h0001;
   end

   a_dev_pull_low: assert property (dev_o == 1'b0) else $error("device drives high");
   a_host_pull_low: assert property (host_o == 1'b0) else $error("host drives high");
   a_line_low: assert property (!dev_oe_n || !host_oe_n |-> !line) else $error("line not low");
   a_line_idle: assert property (dev_oe_n && host_oe_n |-> line) else $error("line not high");
   a_marker_start: assert property ($rose(aresetn) |-> !dev_oe_n) else $error("no marker");
   a_dev_pulse: assert property ($rose(dev_oe_n) && host_oe_n |-> dl_q == 15'h000C || dl_q > 15'h03E8)
      else $error("device pulse length");
   a_sync_gap: assert property ($rose(dev_oe_n) && dl_q == 15'h000C |-> dev_oe_n [*8])
      else $error("window not open");
   a_host_pulse: assert property ($rose(host_oe_n) |-> hl_q inside {15'h0018, 15'h0300, 15'h5E80})
      else $error("host pulse length");
   // Main traffic seen
   c_sync: cover property ($rose(dev_oe_n) && dl_q == 15'h000C);
   c_bit: cover property ($rose(host_oe_n) && hl_q == 15'h0018);
   c_long: cover property ($rose(host_oe_n) && hl_q == 15'h5E80);
endmodule : slc_link_monitor

`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "slc_cfg.svh"

module tb;
   logic aclk, aresetn, wake, irq, polling, rx_chain_en, prog_busy, marker_active;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, q;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [14:0] opcfg_word, limit_word;
   int err_count, num_checks;

   slc_link_if link_i ();
   slc_dev #(.CLK_DIV(8'h03)) slc_dev_i (.aclk, .aresetn, .wake, .opcfg_word, .limit_word, .polling,
      .rx_chain_en, .prog_busy, .marker_active, .link(link_i.dev));
   slc_host #(.CLK_DIV(8'h03)) slc_host_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
      .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
      .s_axi_rresp, .irq, .link(link_i.host));
   slc_link_monitor slc_link_monitor_i (.aclk, .aresetn, .dev_o(link_i.dev_o), .dev_oe_n(link_i.dev_oe_n),
      .host_o(link_i.host_o), .host_oe_n(link_i.host_oe_n), .line(link_i.line));

   // Clock
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : close_out

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One bus access, write or read, held until its answer
   task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, wr, ar, dn;
      logic [1:0] rs;
      dn = 1'b0;
      s_axi_awaddr <= a;
      s_axi_araddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid <= w;
      s_axi_bready <= w;
      s_axi_arvalid <= !w;
      s_axi_rready <= !w;
      for (int n = 0; n < 100 && !dn; n++) begin
         @(negedge aclk);
         aw = s_axi_awready;
         wr = s_axi_wready;
         ar = s_axi_arready;
         dn = w ? s_axi_bvalid : s_axi_rvalid;
         rs = w ? s_axi_bresp : s_axi_rresp;
         q = s_axi_rdata;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (wr) s_axi_wvalid <= 1'b0;
         if (ar) s_axi_arvalid <= 1'b0;
         if (dn) s_axi_bready <= 1'b0;
         if (dn) s_axi_rready <= 1'b0;
      end
      if (dn !== 1'b1) begin
         err_count++;
         close_out();
      end
      chk(rs, er);
      @(posedge aclk);
   endtask : bus

   // Wait for transfer end, then mask and clear the event
   task automatic done_wait;
      int n;
      for (n = 0; n < 40000 && irq !== 1'b1; n++) begin
         @(negedge aclk);
         if (marker_active === 1'b0 && link_i.dev_oe_n === 1'b0)
            chk({rx_chain_en, prog_busy}, {1'b0, !polling});
      end
      if (n == 40000) begin
         err_count++;
         close_out();
      end
      @(posedge aclk);
      bus(1, `SLC_A_IMASK, 0, 0);
      chk(irq, 0);
      bus(1, `SLC_A_IST, 1, 0);
      bus(1, `SLC_A_IMASK, 1, 0);
      chk(irq, 0);
   endtask : done_wait

   task automatic send(input logic [31:0] wd, input logic [31:0] c);
      bus(1, `SLC_A_WORD, wd, 0);
      bus(1, `SLC_A_CTRL, c, 0);
      done_wait();
   endtask : send

   initial begin
      err_count = 0;
      num_checks = 0;
      aresetn = 1'b0;
      wake = 1'b0;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h00000000;
      s_axi_wstrb = 4'hF;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk({marker_active, polling, rx_chain_en, opcfg_word, limit_word}, {3'h6, 15'h0000, 15'h0002});
      bus(1, `SLC_A_IMASK, 1, 0);
      // Short start pulse while the marker runs is ignored
      send(32'h00000006, 32'h00000001);
      chk({marker_active, limit_word}, {1'b1, 15'h0002});
      // Long start pulse cancels marker and programs
      send(32'h00000006, 32'h00000003);
      chk({marker_active, limit_word}, {1'b0, 15'h0006});
      bus(0, `SLC_A_STAT, 0, 0);
      chk(q[1:0], 2'h0);
      // Same word again while receiving gives acknowledge
      wake <= 1'b1;
      @(posedge aclk);
      wake <= 1'b0;
      send(32'h00000006, 32'h00000001);
      bus(0, `SLC_A_STAT, 0, 0);
      chk({q[1:0], polling, limit_word}, {3'h4, 15'h0006});
      // Off command back to polling
      send(32'h00000001, 32'h00000001);
      chk({polling, opcfg_word}, {1'b1, 15'h0001});
      bus(1, 8'h14, 0, 2'h2);
      close_out();
   end
endmodule : tb

`default_nettype wire

// [verilog/slc_cfg.svh]
`ifndef SLC_CFG_SVH
`define SLC_CFG_SVH

// ****************************************
// Clock and basic period
// ****************************************
`define SLC_ACLK_PS        50000
`define SLC_TCLK_PS        2066200
`define SLC_CLK_DIV        ((`SLC_TCLK_PS) / (`SLC_ACLK_PS))

// ****************************************
// Widths and word layout
// ****************************************
`define SLC_WW             15
`define SLC_CW             13
`define SLC_OFF_BIT        0
`define SLC_SEL_BIT        1
`define SLC_LAST_BIT       4'hE
`define SLC_OPCFG_DEF      15'h0000
`define SLC_LIMIT_DEF      15'h0002

// ****************************************
// Link timing in basic periods
// ****************************************
`define SLC_T1_MIN_TCLK    13'h0040
`define SLC_T1_MED_TCLK    13'h1600
`define SLC_T1_LONG_TCLK   13'h1F00
`define SLC_T1_SHORT_HOST  13'h0100
`define SLC_T1_LONG_HOST   13'h1F80
`define SLC_T2_TCLK        13'h0010
`define SLC_T3_TCLK        13'h0004
`define SLC_T4_TCLK        13'h0008
`define SLC_T5_TCLK        13'h0010
`define SLC_T6_TCLK        13'h0020
`define SLC_T7_TCLK        13'h0008
`define SLC_PROG_MIN_TCLK  13'h0004
`define SLC_T8_TCLK        13'h0004
`define SLC_T9_TCLK        13'h0010
`define SLC_RM_HALF_TCLK   13'h0800
`define SLC_RM_DET_TCLK    13'h0400
`define SLC_SYNC_TO_TCLK   13'h0080

// ****************************************
// Controller register map
// ****************************************
`define SLC_A_CTRL         8'h00
`define SLC_A_WORD         8'h04
`define SLC_A_STAT         8'h08
`define SLC_A_IST          8'h0C
`define SLC_A_IMASK        8'h10
`define SLC_CTRL_GO        0
`define SLC_CTRL_LONG      1
`define SLC_RESP_OK        2'h0
`define SLC_RESP_ERR       2'h2

`endif

// [verilog/slc_dev.sv]
`timescale 1ns/1ps
`default_nettype none
`include "slc_cfg.svh"

module slc_dev #(
   parameter logic [7:0]         CLK_DIV    = 8'(`SLC_CLK_DIV),
   parameter logic [`SLC_CW-1:0] START_MED  = `SLC_T1_MED_TCLK,
   parameter logic [`SLC_CW-1:0] START_LONG = `SLC_T1_LONG_TCLK
) (
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // Receiver side
   input  wire logic              wake,
   output var  logic [`SLC_WW-1:0] opcfg_word,
   output var  logic [`SLC_WW-1:0] limit_word,
   output var  logic              polling,
   output var  logic              rx_chain_en,
   output var  logic              prog_busy,
   output var  logic              marker_active,
   // Data line
   slc_link_if.dev                link
);

   // ****************************************
   // State
   // ****************************************
   localparam slc_pkg::slc_dev_s_t RST = '{
      st:      slc_pkg::D_IDLE,
      opcfg:   `SLC_OPCFG_DEF,
      limit:   `SLC_LIMIT_DEF,
      rm_on:   1'b1,
      oe_n:    1'b0,
      sy1:     1'b1,
      sy2:     1'b1,
      default: '0
   };

   slc_pkg::slc_dev_s_t s_q;
   slc_pkg::slc_dev_s_t s_d;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin : p_next
      logic [`SLC_CW-1:0] nc;
      logic [`SLC_WW-1:0] nw;
      nc = '0;
      nw = '0;
      s_d = s_q;
      // Two-stage line synchroniser
      s_d.sy1 = link.line;
      s_d.sy2 = s_q.sy1;
      // Basic period enable
      s_d.tick = 1'b0;
      if (s_q.div == CLK_DIV - 8'h01) begin
         s_d.div  = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.div = s_q.div + 8'h01;
      end
      // Leave polling on request, in any state
      if (wake) begin
         s_d.active = 1'b1;
      end
      if (s_q.tick) begin
         // Marker square wave, equal halves
         if (s_q.rm_on) begin
            if (s_q.rm_cnt == `SLC_RM_HALF_TCLK - 13'h0001) begin
               s_d.rm_cnt = '0;
               s_d.rm_lvl = !s_q.rm_lvl;
            end else begin
               s_d.rm_cnt = s_q.rm_cnt + 13'h0001;
            end
         end
         nc = s_q.cnt + 13'h0001;
         case (s_q.st)
            slc_pkg::D_IDLE: begin
               // Start pulse only counts when we are not pulling low
               if (!s_q.sy2 && s_q.oe_n) begin
                  s_d.st  = slc_pkg::D_START;
                  s_d.cnt = 13'h0001;
               end
            end
            slc_pkg::D_START: begin
               if (!s_q.sy2) begin
                  if (s_q.cnt != '1) begin
                     s_d.cnt = nc;
                  end
               end else begin
                  // Classify start pulse at release
                  s_d.st  = slc_pkg::D_IDLE;
                  s_d.cnt = '0;
                  if (s_q.cnt > START_LONG) begin
                     s_d.opcfg = `SLC_OPCFG_DEF;
                     s_d.limit = `SLC_LIMIT_DEF;
                     s_d.rm_on = 1'b0;
                     s_d.st    = slc_pkg::D_DELAY;
                  end else if (s_q.cnt > `SLC_T1_MIN_TCLK && s_q.cnt < START_MED
                               && !s_q.rm_on) begin
                     s_d.st = slc_pkg::D_DELAY;
                  end
               end
            end
            slc_pkg::D_DELAY: begin
               if (s_q.cnt == `SLC_T2_TCLK - 13'h0001) begin
                  s_d.st   = slc_pkg::D_BITS;
                  s_d.cnt  = '0;
                  s_d.bitn = '0;
                  s_d.lowc = '0;
                  s_d.oe_n = 1'b0;
               end else begin
                  s_d.cnt = nc;
               end
            end
            slc_pkg::D_BITS: begin
               // Count host low time inside the bit window
               if (s_q.cnt >= `SLC_T4_TCLK && s_q.cnt < `SLC_T4_TCLK + `SLC_T5_TCLK
                   && !s_q.sy2) begin
                  s_d.lowc = s_q.lowc + 13'h0001;
               end
               if (s_q.cnt == `SLC_T6_TCLK - 13'h0001) begin
                  nw = s_q.word;
                  nw[s_q.bitn] = (s_q.lowc < `SLC_PROG_MIN_TCLK);
                  s_d.word = nw;
                  s_d.lowc = '0;
                  s_d.cnt  = '0;
                  if (s_q.bitn == `SLC_LAST_BIT) begin
                     // Compare with the register the word targets
                     s_d.st   = slc_pkg::D_EQ;
                     s_d.eq   = (nw == (nw[`SLC_SEL_BIT] ? s_q.limit : s_q.opcfg));
                     s_d.oe_n = !s_d.eq;
                  end else begin
                     s_d.bitn = s_q.bitn + 4'h1;
                     s_d.oe_n = 1'b0;
                  end
               end else begin
                  s_d.cnt  = nc;
                  s_d.oe_n = (nc >= `SLC_T3_TCLK);
               end
            end
            slc_pkg::D_EQ: begin
               if (s_q.cnt == `SLC_T9_TCLK - 13'h0001) begin
                  s_d.st  = slc_pkg::D_IDLE;
                  s_d.cnt = '0;
                  if (s_q.word[`SLC_SEL_BIT]) begin
                     s_d.limit = s_q.word;
                  end else begin
                     s_d.opcfg = s_q.word;
                  end
                  if (s_q.word[`SLC_OFF_BIT]) begin
                     s_d.active = 1'b0;
                  end
               end else begin
                  s_d.cnt  = nc;
                  s_d.oe_n = !(s_q.eq && nc < `SLC_T8_TCLK);
               end
            end
            default: begin
               s_d.st = slc_pkg::D_IDLE;
            end
         endcase
      end
      // Line drive: marker when idle, released while measuring
      if (s_d.st == slc_pkg::D_IDLE) begin
         s_d.oe_n = !(s_d.rm_on && !s_d.rm_lvl);
      end else if (s_d.st == slc_pkg::D_START || s_d.st == slc_pkg::D_DELAY) begin
         s_d.oe_n = 1'b1;
      end
      s_d.dat = 1'b0;
      // Receive chain off during any transfer
      s_d.rx_en = (s_d.st == slc_pkg::D_IDLE) && s_d.active;
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign opcfg_word    = s_q.opcfg;
   assign limit_word    = s_q.limit;
   assign polling       = !s_q.active;
   assign rx_chain_en   = s_q.rx_en;
   assign prog_busy     = !s_q.rx_en && s_q.active;
   assign marker_active = s_q.rm_on;
   assign link.dev_o    = s_q.dat;
   assign link.dev_oe_n = s_q.oe_n;

endmodule : slc_dev

`default_nettype wire

// [verilog/slc_host.sv]
`timescale 1ns/1ps
`default_nettype none
`include "slc_cfg.svh"

module slc_host #(
   parameter logic [7:0]         CLK_DIV     = 8'(`SLC_CLK_DIV),
   parameter logic [`SLC_CW-1:0] START_SHORT = `SLC_T1_SHORT_HOST,
   parameter logic [`SLC_CW-1:0] START_LONG  = `SLC_T1_LONG_HOST
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Write address and data
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // Write response
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output var  logic [1:0]  s_axi_bresp,
   // Read
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   // Interrupt
   output var  logic        irq,
   // Data line
   slc_link_if.host         link
);

   // Register index from byte address
   function automatic slc_pkg::slc_reg_t reg_of(input logic [7:0] a);
      case (a)
         `SLC_A_CTRL:  reg_of = slc_pkg::R_CTRL;
         `SLC_A_WORD:  reg_of = slc_pkg::R_WORD;
         `SLC_A_STAT:  reg_of = slc_pkg::R_STAT;
         `SLC_A_IST:   reg_of = slc_pkg::R_IST;
         `SLC_A_IMASK: reg_of = slc_pkg::R_IMASK;
         default:      reg_of = slc_pkg::R_NONE;
      endcase
   endfunction : reg_of

   localparam slc_pkg::slc_host_s_t RST = '{
      st: slc_pkg::H_IDLE, oe_n: 1'b1, sy1: 1'b1, sy2: 1'b1, default: '0};

   slc_pkg::slc_host_s_t s_q;
   slc_pkg::slc_host_s_t s_d;

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin : p_next
      logic [1:0]           set;
      logic [1:0]           clr;
      logic                 nxt;
      slc_pkg::slc_reg_t    wi;
      slc_pkg::slc_reg_t    ri;
      set = '0;
      clr = '0;
      nxt = 1'b0;
      wi  = reg_of(s_axi_awaddr);
      ri  = reg_of(s_axi_araddr);
      s_d = s_q;
      s_d.sy1 = link.line;
      s_d.sy2 = s_q.sy1;
      s_d.tick = 1'b0;
      if (s_q.div == CLK_DIV - 8'h01) begin
         s_d.div  = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.div = s_q.div + 8'h01;
      end
      // Link sequencer, one step per basic period
      if (s_q.tick) begin
         case (s_q.st)
            slc_pkg::H_IDLE: begin
               // Long idle low means reset marker
               if (!s_q.sy2) begin
                  if (s_q.lowc == `SLC_RM_DET_TCLK - 13'h0001) begin
                     set[1] = 1'b1;
                  end
                  if (s_q.lowc != `SLC_RM_DET_TCLK) begin
                     s_d.lowc = s_q.lowc + 13'h0001;
                  end
               end else begin
                  s_d.lowc = '0;
               end
            end
            slc_pkg::H_START: begin
               if (s_q.oe_n) begin
                  // Pull low only on a released line, so the far end sees the whole pulse
                  if (s_q.sy2) begin
                     s_d.oe_n = 1'b0;
                     s_d.cnt  = '0;
                  end
               end else if (s_q.cnt == (s_q.long_p ? START_LONG : START_SHORT) - 13'h0001) begin
                  s_d.oe_n = 1'b1;
                  s_d.st   = slc_pkg::H_WSYNC;
                  s_d.cnt  = '0;
                  s_d.bitn = '0;
                  s_d.lw   = 1'b0;
               end else begin
                  s_d.cnt = s_q.cnt + 13'h0001;
               end
            end
            slc_pkg::H_WSYNC: begin
               s_d.cnt = s_q.cnt + 13'h0001;
               if (!s_q.sy2) begin
                  s_d.lw = 1'b1;
               end else if (s_q.lw) begin
                  s_d.st  = slc_pkg::H_WGAP;
                  s_d.cnt = '0;
               end
               if (s_q.cnt == `SLC_SYNC_TO_TCLK) begin
                  s_d.st = slc_pkg::H_IDLE;
                  set[0] = 1'b1;
               end
            end
            slc_pkg::H_WGAP: begin
               if (s_q.cnt == `SLC_T4_TCLK - `SLC_T3_TCLK) begin
                  if (!s_q.word[s_q.bitn]) begin
                     s_d.st   = slc_pkg::H_DRV;
                     s_d.cnt  = '0;
                     s_d.oe_n = 1'b0;
                  end else begin
                     nxt = 1'b1;
                  end
               end else begin
                  s_d.cnt = s_q.cnt + 13'h0001;
               end
            end
            slc_pkg::H_DRV: begin
               if (s_q.cnt == `SLC_T7_TCLK - 13'h0001) begin
                  s_d.oe_n = 1'b1;
                  nxt      = 1'b1;
               end else begin
                  s_d.cnt = s_q.cnt + 13'h0001;
               end
            end
            slc_pkg::H_ACK: begin
               if (!s_q.sy2) begin
                  s_d.ack = 1'b1;
               end
               if (s_q.cnt == `SLC_T6_TCLK + `SLC_T9_TCLK) begin
                  s_d.st = slc_pkg::H_IDLE;
                  set[0] = 1'b1;
               end else begin
                  s_d.cnt = s_q.cnt + 13'h0001;
               end
            end
            default: begin
               s_d.st = slc_pkg::H_IDLE;
            end
         endcase
         // Advance to next bit or to the acknowledge window
         if (nxt) begin
            s_d.cnt = '0;
            s_d.lw  = 1'b0;
            if (s_q.bitn == `SLC_LAST_BIT) begin
               s_d.st = slc_pkg::H_ACK;
            end else begin
               s_d.bitn = s_q.bitn + 4'h1;
               s_d.st   = slc_pkg::H_WSYNC;
            end
         end
      end
      // Write channel: address and data taken together
      s_d.awr = 1'b0;
      s_d.wr  = 1'b0;
      if (s_q.bv && s_axi_bready) begin
         s_d.bv = 1'b0;
      end
      if (s_axi_awvalid && s_axi_wvalid && !s_q.awr && !s_q.bv) begin
         s_d.awr = 1'b1;
         s_d.wr  = 1'b1;
      end
      if (s_q.awr) begin
         s_d.bv = 1'b1;
         s_d.br = (wi == slc_pkg::R_NONE) ? `SLC_RESP_ERR : `SLC_RESP_OK;
         if (s_axi_wstrb[0]) begin
            case (wi)
               slc_pkg::R_CTRL: begin
                  if (s_axi_wdata[`SLC_CTRL_GO] && s_q.st == slc_pkg::H_IDLE) begin
                     s_d.st     = slc_pkg::H_START;
                     s_d.long_p = s_axi_wdata[`SLC_CTRL_LONG];
                     s_d.cnt    = '0;
                     s_d.ack    = 1'b0;
                  end
               end
               slc_pkg::R_WORD:  s_d.word[7:0] = s_axi_wdata[7:0];
               slc_pkg::R_IST:   clr = s_axi_wdata[1:0];
               slc_pkg::R_IMASK: s_d.imask = s_axi_wdata[1:0];
               default: begin
               end
            endcase
         end
         if (s_axi_wstrb[1] && wi == slc_pkg::R_WORD) begin
            s_d.word[`SLC_WW-1:8] = s_axi_wdata[`SLC_WW-1:8];
         end
      end
      // Read channel
      s_d.arr = 1'b0;
      if (s_q.rv && s_axi_rready) begin
         s_d.rv = 1'b0;
      end
      if (s_axi_arvalid && !s_q.arr && !s_q.rv) begin
         s_d.arr = 1'b1;
      end
      if (s_q.arr) begin
         s_d.rv = 1'b1;
         s_d.rr = (ri == slc_pkg::R_NONE) ? `SLC_RESP_ERR : `SLC_RESP_OK;
         case (ri)
            slc_pkg::R_CTRL:  s_d.rd = {31'h00000000, s_q.long_p} << `SLC_CTRL_LONG;
            slc_pkg::R_WORD:  s_d.rd = {17'h00000, s_q.word};
            slc_pkg::R_STAT:  s_d.rd = {30'h00000000, s_q.ack, s_q.st != slc_pkg::H_IDLE};
            slc_pkg::R_IST:   s_d.rd = {30'h00000000, s_q.ist};
            slc_pkg::R_IMASK: s_d.rd = {30'h00000000, s_q.imask};
            default:          s_d.rd = '0;
         endcase
      end
      // Sticky events: a set in the clearing cycle wins
      s_d.ist = (s_q.ist & ~clr) | set;
      s_d.irq = |(s_d.ist & s_d.imask);
      s_d.dat = 1'b0;
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign s_axi_awready  = s_q.awr;
   assign s_axi_wready   = s_q.wr;
   assign s_axi_bvalid   = s_q.bv;
   assign s_axi_bresp    = s_q.br;
   assign s_axi_arready  = s_q.arr;
   assign s_axi_rvalid   = s_q.rv;
   assign s_axi_rdata    = s_q.rd;
   assign s_axi_rresp    = s_q.rr;
   assign irq            = s_q.irq;
   assign link.host_o    = s_q.dat;
   assign link.host_oe_n = s_q.oe_n;

endmodule : slc_host

`default_nettype wire

// [verilog/slc_link_if.sv]
`timescale 1ns/1ps
`default_nettype none

interface slc_link_if;
   logic dev_o;
   logic dev_oe_n;
   logic host_o;
   logic host_oe_n;
   logic line;

   // Open-drain wire with pull-up: low if either end drives low
   assign line = !((!dev_oe_n && !dev_o) || (!host_oe_n && !host_o));

   modport dev  (input line, output dev_o, dev_oe_n);
   modport host (input line, output host_o, host_oe_n);
endinterface : slc_link_if

`default_nettype wire

// [verilog/slc_pkg.sv]
`default_nettype none
`include "slc_cfg.svh"

package slc_pkg;

   // ****************************************
   // Device end
   // ****************************************
   typedef enum logic [2:0] {D_IDLE, D_START, D_DELAY, D_BITS, D_EQ} slc_dev_st_t;

   typedef struct packed {
      logic                sy1;
      logic                sy2;
      logic [7:0]          div;
      logic                tick;
      slc_dev_st_t         st;
      logic [`SLC_CW-1:0]  cnt;
      logic [`SLC_CW-1:0]  lowc;
      logic [3:0]          bitn;
      logic [`SLC_WW-1:0]  word;
      logic                eq;
      logic                rm_on;
      logic                rm_lvl;
      logic [`SLC_CW-1:0]  rm_cnt;
      logic [`SLC_WW-1:0]  opcfg;
      logic [`SLC_WW-1:0]  limit;
      logic                active;
      logic                oe_n;
      logic                dat;
      logic                rx_en;
   } slc_dev_s_t;

   // ****************************************
   // Controller end
   // ****************************************
   typedef enum logic [2:0] {H_IDLE, H_START, H_WSYNC, H_WGAP, H_DRV, H_ACK} slc_host_st_t;

   typedef enum logic [2:0] {R_CTRL, R_WORD, R_STAT, R_IST, R_IMASK, R_NONE} slc_reg_t;

   typedef struct packed {
      logic                sy1;
      logic                sy2;
      logic [7:0]          div;
      logic                tick;
      slc_host_st_t        st;
      logic [`SLC_CW-1:0]  cnt;
      logic [`SLC_CW-1:0]  lowc;
      logic [3:0]          bitn;
      logic [`SLC_WW-1:0]  word;
      logic                long_p;
      logic                lw;
      logic                ack;
      logic [1:0]          ist;
      logic [1:0]          imask;
      logic                irq;
      logic                oe_n;
      logic                dat;
      logic                awr;
      logic                wr;
      logic                bv;
      logic [1:0]          br;
      logic                arr;
      logic                rv;
      logic [31:0]         rd;
      logic [1:0]          rr;
   } slc_host_s_t;

endpackage : slc_pkg

`default_nettype wire
